// *** inc/burst_port_pkg.sv ***
// Package for the burst-handling slave port: widths, settings and carriers
package burst_port_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int BCNT_W = 4;
  localparam int SYM_PER_WORD = 4;
  localparam int SYM_SHIFT = 2;
  // Wrap boundary in bytes on a byte-addressed bus (32 bytes across 4-byte words)
  localparam logic [ADDR_W-1:0] WRAP_BYTES = 16'h0020;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
  localparam logic [BCNT_W-1:0] BCNT_ZERO = 4'h0;
  localparam logic [BCNT_W-1:0] BCNT_ONE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
  localparam logic [ADDR_W-1:0] WORD_BYTES = 16'h0004;

  typedef enum logic [1:0] {
    UNIT_WORDS = 2'h1,
    UNIT_SYMBOLS = 2'h2
  } unit_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_BURST = 2'h2
  } state_type;

  typedef struct packed {
    logic read;
    logic write;
    logic burst_start;
    logic [ADDR_W-1:0] address;
    logic [BCNT_W-1:0] burst_length;
  } cmd_type;

  typedef struct packed {
    logic address_unit_select;
    logic burst_length_unit;
    logic burst_hold_constant;
    logic wrapping_burst_enable;
    logic use_burst_start;
  } cfg_type;

  typedef struct packed {
    state_type state;
    logic [ADDR_W-1:0] cur_addr;
    logic [ADDR_W-1:0] base_addr;
    logic [BCNT_W-1:0] beats_left;
    logic is_write;
    logic beat_valid;
    logic beat_write;
    logic beat_first;
    logic beat_last;
    logic [ADDR_W-1:0] beat_addr;
  } regs_type;
endpackage

// *** rtl/burst_slave_port.sv ***
// Burst tracking and address generation for a memory-mapped slave port
// What this block does
// - Without start pulse, count beats to find bursts
// - Burst start use is optional, off preferred
// - Addresses counted in words or symbols
// - Burst length in words or symbols
// - Sample address and length on first beat
// - Wrapping bursts wrap back at boundary
// - Wrap counts only low bits, upper kept
`timescale 1ns/1ps
`default_nettype none
module burst_slave_port (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire burst_port_pkg::cmd_type cmd,
  input wire burst_port_pkg::cfg_type cfg,
  input wire logic core_stall,
  output logic stall_request,
  output logic beat_valid,
  output logic beat_write,
  output logic beat_first,
  output logic beat_last,
  output logic [burst_port_pkg::ADDR_W-1:0] beat_addr,
  output logic burst_active
);
  burst_port_pkg::regs_type r_ff;
  burst_port_pkg::regs_type nxt_r;
  logic accept;
  logic new_burst;
  logic [burst_port_pkg::BCNT_W-1:0] words_len;
  logic [burst_port_pkg::ADDR_W-1:0] step;
  logic [burst_port_pkg::ADDR_W-1:0] wrap_mask;

  // Length in beats; a symbol count is turned into whole words
  function automatic logic [burst_port_pkg::BCNT_W-1:0] to_beats(
    input logic [burst_port_pkg::BCNT_W-1:0] len,
    input logic sym_units
  );
    logic [burst_port_pkg::BCNT_W-1:0] w;
    w = len >> burst_port_pkg::SYM_SHIFT;
    if (sym_units && (w == burst_port_pkg::BCNT_ZERO)) begin
      w = burst_port_pkg::BCNT_ONE;
    end
    return sym_units ? w : len;
  endfunction

  // Stall at the core's request or while in reset; a new command is taken when not stalled
  assign stall_request = core_stall || !rst_n;
  assign accept = (cmd.read || cmd.write) && !stall_request;
  // Start found by the beat count running out or, when enabled, by the pulse
  assign new_burst = accept && ((r_ff.state == burst_port_pkg::ST_IDLE) ||
                     (cfg.use_burst_start && cmd.burst_start));
  assign words_len = to_beats(cmd.burst_length, cfg.burst_length_unit);
  assign step = cfg.address_unit_select ? burst_port_pkg::WORD_BYTES
                                        : burst_port_pkg::ADDR_ONE;
  // Wrap window scales with address unit: bytes or words
  assign wrap_mask = cfg.address_unit_select
                   ? (burst_port_pkg::WRAP_BYTES - burst_port_pkg::ADDR_ONE)
                   : ((burst_port_pkg::WRAP_BYTES >> burst_port_pkg::SYM_SHIFT)
                      - burst_port_pkg::ADDR_ONE);

  always_comb begin
    logic [burst_port_pkg::ADDR_W-1:0] a;
    logic [burst_port_pkg::ADDR_W-1:0] inc;
    a = burst_port_pkg::ADDR_ZERO;
    inc = burst_port_pkg::ADDR_ZERO;
    nxt_r = r_ff;
    nxt_r.beat_valid = 1'b0;
    nxt_r.beat_first = 1'b0;
    nxt_r.beat_last = 1'b0;
    case (r_ff.state)
      burst_port_pkg::ST_IDLE: begin
        if (new_burst) begin
          a = cmd.address;
          nxt_r.base_addr = cmd.address;
          nxt_r.is_write = cmd.write;
          nxt_r.beat_first = 1'b1;
        end
      end
      burst_port_pkg::ST_BURST: begin
        if (new_burst) begin
          a = cmd.address;
          nxt_r.base_addr = cmd.address;
          nxt_r.is_write = cmd.write;
          nxt_r.beat_first = 1'b1;
        end else if (cfg.burst_hold_constant) begin
          a = r_ff.cur_addr;
        end else begin
          a = r_ff.cur_addr;
        end
      end
      default: begin
        nxt_r.state = burst_port_pkg::ST_IDLE;
      end
    endcase
    if (accept) begin
      nxt_r.beat_valid = 1'b1;
      nxt_r.beat_write = new_burst ? cmd.write : r_ff.is_write;
      nxt_r.beat_addr = a;
      inc = a + step;
      if (cfg.wrapping_burst_enable) begin
        nxt_r.cur_addr = (a & ~wrap_mask) | (inc & wrap_mask);
      end else begin
        nxt_r.cur_addr = inc;
      end
      if (new_burst) begin
        nxt_r.beats_left = words_len - burst_port_pkg::BCNT_ONE;
      end else begin
        nxt_r.beats_left = r_ff.beats_left - burst_port_pkg::BCNT_ONE;
      end
      if (nxt_r.beats_left == burst_port_pkg::BCNT_ZERO) begin
        nxt_r.state = burst_port_pkg::ST_IDLE;
        nxt_r.beat_last = 1'b1;
      end else begin
        nxt_r.state = burst_port_pkg::ST_BURST;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r_ff <= '{state: burst_port_pkg::ST_IDLE, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign beat_valid = r_ff.beat_valid;
  assign beat_write = r_ff.beat_write;
  assign beat_first = r_ff.beat_first;
  assign beat_last = r_ff.beat_last;
  assign beat_addr = r_ff.beat_addr;
  assign burst_active = (r_ff.state == burst_port_pkg::ST_BURST);

  // Start of burst always shows as first beat next cycle
  property p_first_beat;
    @(posedge clk_sys) disable iff (!rst_n)
      new_burst |=> beat_first && beat_valid;
  endproperty
  a_first_beat: assert property (p_first_beat) else $error("first beat missing");

  property p_first_addr;
    @(posedge clk_sys) disable iff (!rst_n)
      new_burst |=> beat_addr == $past(cmd.address);
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("first address wrong");

  property p_incr;
    @(posedge clk_sys) disable iff (!rst_n)
      (accept && !new_burst && !cfg.wrapping_burst_enable)
      |=> beat_addr == $past(r_ff.cur_addr);
  endproperty
  a_incr: assert property (p_incr) else $error("increment address wrong");

  property p_step;
    @(posedge clk_sys) disable iff (!rst_n)
      (accept && !cfg.wrapping_burst_enable)
      |=> r_ff.cur_addr == r_ff.beat_addr + $past(step);
  endproperty
  a_step: assert property (p_step) else $error("address step wrong");

  property p_wrap_upper;
    @(posedge clk_sys) disable iff (!rst_n)
      (accept && cfg.wrapping_burst_enable)
      |=> (r_ff.cur_addr & ~$past(wrap_mask)) == (r_ff.beat_addr & ~$past(wrap_mask));
  endproperty
  a_wrap_upper: assert property (p_wrap_upper) else $error("wrap changed upper bits");

  // Low bits of the following address inside the wrap window
  logic [burst_port_pkg::ADDR_W-1:0] wrap_low_next;
  assign wrap_low_next = ((nxt_r.beat_addr + step) & wrap_mask);
  property p_wrap_back;
    @(posedge clk_sys) disable iff (!rst_n)
      (accept && cfg.wrapping_burst_enable && (wrap_low_next == burst_port_pkg::ADDR_ZERO))
      |=> (r_ff.cur_addr & $past(wrap_mask)) == burst_port_pkg::ADDR_ZERO;
  endproperty
  a_wrap_back: assert property (p_wrap_back) else $error("wrap did not return");

  property p_last_idle;
    @(posedge clk_sys) disable iff (!rst_n)
      beat_last |-> !burst_active;
  endproperty
  a_last_idle: assert property (p_last_idle) else $error("burst not ended");

  property p_single;
    @(posedge clk_sys) disable iff (!rst_n)
      (new_burst && words_len == burst_port_pkg::BCNT_ONE) |=> beat_last && beat_first;
  endproperty
  a_single: assert property (p_single) else $error("single beat burst wrong");

  // The beat count alone must close a burst, since the start pulse may be absent
  sequence s_final_beat_taken;
    accept && !new_burst && (r_ff.beats_left == burst_port_pkg::BCNT_ONE);
  endsequence
  sequence s_burst_closed;
    beat_valid && beat_last && !burst_active;
  endsequence
  property p_count_end;
    @(posedge clk_sys) disable iff (!rst_n)
      s_final_beat_taken |=> s_burst_closed;
  endproperty
  a_count_end: assert property (p_count_end) else $error("burst did not end on count");

  sequence s_mid_beat_taken;
    accept && !new_burst && (r_ff.beats_left > burst_port_pkg::BCNT_ONE);
  endsequence
  sequence s_burst_still_open;
    beat_valid && !beat_last && burst_active;
  endsequence
  property p_count_mid;
    @(posedge clk_sys) disable iff (!rst_n)
      s_mid_beat_taken |=> s_burst_still_open;
  endproperty
  a_count_mid: assert property (p_count_mid) else $error("burst ended early");

  // A stalled cycle must never produce a beat
  property p_refuse;
    @(posedge clk_sys) disable iff (!rst_n)
      stall_request |=> !beat_valid;
  endproperty
  a_refuse: assert property (p_refuse) else $error("beat taken under stall");
endmodule
`default_nettype wire

// *** test/burst_master_model.sv ***
// Bus master model that issues bursts toward the slave port
`timescale 1ns/1ps
`default_nettype none
module burst_master_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic stall_request,
  input wire logic go,
  input wire burst_port_pkg::cmd_type go_cmd,
  input wire logic [3:0] go_beats,
  output var burst_port_pkg::cmd_type cmd,
  output logic ready
);
  logic [3:0] left;
  initial begin
    cmd = '0;
    left = 4'h0;
  end
  // A new burst may follow the last beat with no idle cycle
  assign ready = left == 4'h0 || (left == 4'h1 && !stall_request);
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd <= '0;
      left <= 4'h0;
    end else if (go && ready) begin
      cmd <= go_cmd;
      left <= go_beats;
    end else if (left != 4'h0 && !stall_request) begin
      // Address and length are garbage after the first beat
      cmd.burst_start <= 1'b0;
      cmd.address <= ~cmd.address;
      cmd.burst_length <= ~cmd.burst_length;
      cmd.read <= cmd.read && left != 4'h1;
      cmd.write <= cmd.write && left != 4'h1;
      left <= left - 4'h1;
    end else begin
      // The start pulse lasts one cycle even while the slave stalls
      cmd.burst_start <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** test/burst_slave_port_tb.sv ***
// Self-checking bench for the burst slave port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module burst_slave_port_tb;
  logic clk_sys, rst_n, core_stall, stall_en, go, ready;
  logic stall_request, beat_valid, beat_write, beat_first, beat_last, burst_active;
  logic [15:0] beat_addr;
  logic [3:0] go_beats;
  burst_port_pkg::cmd_type cmd, go_cmd;
  burst_port_pkg::cfg_type cfg;
  logic [18:0] got[$], exp[$];
  int miscompares, n_checks, k;
  burst_slave_port burst_slave_port_inst (.clk_sys(clk_sys), .rst_n(rst_n), .cmd(cmd),
    .cfg(cfg), .core_stall(core_stall), .stall_request(stall_request),
    .beat_valid(beat_valid), .beat_write(beat_write), .beat_first(beat_first),
    .beat_last(beat_last), .beat_addr(beat_addr), .burst_active(burst_active));
  burst_master_model burst_master_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .stall_request(stall_request), .go(go), .go_cmd(go_cmd), .go_beats(go_beats),
    .cmd(cmd), .ready(ready));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    // Stall every other cycle to exercise holding under stall
    core_stall <= stall_en && !core_stall;
    if (beat_valid === 1'b1) got.push_back({beat_first, beat_last, beat_write, beat_addr});
  end
  task automatic conclude();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic burst(input logic w, input logic [15:0] a, input logic [3:0] l,
      input logic [3:0] n, input logic [15:0] step, input logic [15:0] wmask);
    logic [15:0] x;
    for (int i = 0; i < n; i++) begin
      x = 16'(a + step * i);
      // Wrapping keeps every bit above the window
      if (wmask != 16'h0000) x = (a & ~wmask) | (x & wmask);
      exp.push_back({i == 0, i == n - 1, w, x});
    end
    go <= 1'b1;
    go_cmd <= '{!w, w, 1'b1, a, l};
    go_beats <= n;
    @(posedge clk_sys);
    for (k = 0; k < 50 && !ready; k++) @(posedge clk_sys);
    `CHK(ready, 1'b1)
    if (ready !== 1'b1) conclude();
  endtask
  task automatic drain(input int id);
    go <= 1'b0;
    for (k = 0; k < 100 && got.size() < exp.size(); k++) @(posedge clk_sys);
    if (k == 100) begin
      miscompares++;
      conclude();
    end
    @(posedge clk_sys);
    `CHK(got.size(), exp.size())
    `CHK(burst_active, 1'b0)
    for (int i = 0; i < exp.size() && i < got.size(); i++) `CHK(got[i], exp[i])
    got.delete();
    exp.delete();
    $display("test %0d done", id);
  endtask
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    stall_en = 1'b0;
    core_stall = 1'b0;
    go_cmd = '0;
    go_beats = 4'h0;
    cfg = '0;
    miscompares = 0;
    n_checks = 0;
    repeat (3) @(posedge clk_sys);
    `CHK(stall_request, 1'b1)
    rst_n <= 1'b1;
    // Byte addresses, word lengths, wrapping, start pulse honoured
    cfg <= 5'h13;
    burst(1'b1, 16'h120C, 4'h8, 4'h8, 16'h0004, 16'h001F);
    drain(1);
    // Symbol lengths, no start pulse, bursts back to back, a short one rounded up
    cfg <= 5'h18;
    burst(1'b0, 16'h0100, 4'h8, 4'h2, 16'h0004, 16'h0000);
    burst(1'b1, 16'h0200, 4'hC, 4'h3, 16'h0004, 16'h0000);
    burst(1'b0, 16'h0300, 4'h2, 4'h1, 16'h0004, 16'h0000);
    drain(2);
    // Word addresses under stall, constant-hold declared
    cfg <= 5'h05;
    stall_en <= 1'b1;
    burst(1'b1, 16'h0040, 4'h5, 4'h5, 16'h0001, 16'h0000);
    burst(1'b0, 16'hFFFE, 4'h3, 4'h3, 16'h0001, 16'h0000);
    drain(3);
    // Word addresses wrapping inside an eight-word window, under stall
    cfg <= 5'h02;
    burst(1'b0, 16'h0035, 4'h4, 4'h4, 16'h0001, 16'h0007);
    drain(4);
    conclude();
  end
endmodule
`default_nettype wire
